//--- hdl/fwid_core.sv
// Summary of operation
// [RQ1] host wakes device with one byte ABH framed by chip select
// [RQ2] device returns to standby within wake recovery time after select rises
// [RQ3] host keeps select high during wake recovery, no new command
// [RQ4] in deep power-down every instruction except wake is ignored
// [RQ5] page size one-time programmable; binary never reverts to 264; here each reset reloads page_stored and page_binary from page_strap
// [RQ6] unprogrammed page-size setting selects 264-byte pages
// [RQ7] config command 3D 2A 80 A6 in one frame; program starts at select rise
// [RQ8] status reports busy for the whole config program interval
// [RQ9] new binary page size takes effect only after power cycle
// [RQ10] host rechecks page-size bit after power loss and reissues command
// [RQ11] status bit 0 is one for 256-byte pages, zero for 264
// [RQ12] status bit 7 zero while busy, one when ready
// [RQ13] opcode 9FH starts identification output on following clocks
// [RQ14] order: maker byte, two part bytes, extra-info count byte
// [RQ15] select rising ends identification at once, output goes high impedance
// [RQ16] first part byte: family bits 7..5, density bits 4..0
// [RQ17] second part byte: cell level bits 7..5, version bits 4..0
// [RQ18] host treats 7FH maker bytes as continuation codes
// [RQ19] host starts nothing during a group A command
// [RQ20] status and identification reads are accepted while self-timed busy
// [RQ21] host uses the other buffer for group C during group B
// [RQ22] host issues only status reads during group D self-timed work
// [RQ23] partial-byte or mismatched wake or config frames are ignored
`timescale 1ns/100ps
`default_nettype none
`include "fwid_map.svh"
module fwid_core #(
    parameter int unsigned WAKE_CYC = `FWID_WAKE_CYC,
    parameter int unsigned PROG_CYC = `FWID_PROG_CYC
) (
    input  wire logic  clk,
    input  wire logic  reset_n,
    input  wire logic  cs_n,
    input  wire logic  sck,
    input  wire logic  si,
    input  wire logic  page_strap,
    output logic       so_out,
    output logic       so_oe,
    output logic       busy,
    output logic       deep_sleep,
    output logic       page_binary,
    output logic       page_stored
);
    typedef enum logic [1:0] {FWID_ST_AWAKE, FWID_ST_ENTER, FWID_ST_ASLEEP, FWID_ST_WAKE}
        fwid_pwr_t;

    fwid_pkg::fwid_link_t link;
    fwid_pwr_t            pwr;
    fwid_pkg::fwid_cmd_t  cmd;
    logic [7:0]  shift;
    logic [2:0]  bit_cnt;
    logic [2:0]  byte_cnt;
    logic        whole_byte;
    logic [1:0]  cfg_match;
    logic        cfg_ok;
    logic        wake_ok;
    logic        sleep_ok;
    logic        sel_last;
    logic [31:0] timer;
    logic        prog_run;
    logic [7:0]  out_byte;
    logic [2:0]  out_bit;
    logic [1:0]  out_idx;
    logic [1:0]  strap_sync;
    logic [1:0]  strap_age;

    fwid_sync u_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .cs_n_pin (cs_n),
        .sck_pin  (sck),
        .si_pin   (si),
        .link     (link)
    );

    function automatic logic [7:0] id_byte(input logic [1:0] idx);
        unique case (idx)
            2'd0: id_byte = `FWID_MAKER_CODE;                  // RQ14
            2'd1: id_byte = {`FWID_FAMILY, `FWID_DENSITY};     // RQ16
            2'd2: id_byte = {`FWID_CELL_LEVEL, `FWID_VERSION}; // RQ17
            2'd3: id_byte = `FWID_EXTRA_COUNT;                 // RQ14
        endcase
    endfunction

    wire       frame_end  = sel_last & ~link.sel;
    wire       frame_go   = ~sel_last & link.sel;
    wire [7:0] next_shift = {shift[6:0], link.si};
    wire       byte_done  = link.sck.rise & (bit_cnt == 3'd7);
    wire       awake      = (pwr == FWID_ST_AWAKE);
    wire       busy_now   = prog_run | (pwr == FWID_ST_WAKE) | (pwr == FWID_ST_ENTER);
    wire [7:0] status_byte = {~busy_now, 1'b0, `FWID_ST_DENSITY, 1'b0, page_binary}; // RQ11 RQ12
    wire [7:0] cfg_expect  = (byte_cnt == 3'd0) ? `FWID_OP_CFG0 :
                             (byte_cnt == 3'd1) ? `FWID_OP_CFG1 :
                             (byte_cnt == 3'd2) ? `FWID_OP_CFG2 : `FWID_OP_CFG3;
    wire [7:0] id_now      = id_byte(out_idx);

    assign busy = busy_now;
    assign deep_sleep = (pwr == FWID_ST_ASLEEP);

    // bit and byte capture, opcode decode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_last   <= 1'b0;
            shift      <= 8'h00;
            bit_cnt    <= 3'd0;
            byte_cnt   <= 3'd0;
            whole_byte <= 1'b1;
            cfg_match  <= 2'd0;
            cfg_ok     <= 1'b0;
            wake_ok    <= 1'b0;
            sleep_ok   <= 1'b0;
            cmd        <= fwid_pkg::FWID_CMD_NONE;
        end else begin
            sel_last <= link.sel;
            if (frame_go) begin
                bit_cnt    <= 3'd0;
                byte_cnt   <= 3'd0;
                whole_byte <= 1'b1;
                cfg_ok     <= 1'b0;
                wake_ok    <= 1'b0;
                sleep_ok   <= 1'b0;
                cfg_match  <= 2'd0;
                cmd        <= fwid_pkg::FWID_CMD_NONE;
            end else if (link.sel && link.sck.rise) begin
                shift      <= next_shift;
                bit_cnt    <= bit_cnt + 3'd1;
                whole_byte <= (bit_cnt == 3'd7);                        // RQ23
                if (bit_cnt == 3'd7 && byte_cnt != 3'd7) begin
                    byte_cnt <= byte_cnt + 3'd1;
                end
                if (byte_done) begin
                    wake_ok  <= (byte_cnt == 3'd0) && (next_shift == `FWID_OP_WAKE); // RQ1 RQ23
                    sleep_ok <= awake && (byte_cnt == 3'd0) && (next_shift == `FWID_OP_SLEEP);
                    if (byte_cnt < 3'd4 && next_shift == cfg_expect && cfg_match == byte_cnt[1:0])
                        cfg_match <= byte_cnt[1:0] + 2'd1;
                    cfg_ok <= awake && !busy_now && (byte_cnt == 3'd3) && (cfg_match == 2'd3)
                              && (next_shift == `FWID_OP_CFG3);           // RQ7 RQ23
                    if (byte_cnt == 3'd0) begin
                        if (!awake)
                            cmd <= fwid_pkg::FWID_CMD_IGNORE;            // RQ4
                        else if (next_shift == `FWID_OP_IDENT)
                            cmd <= fwid_pkg::FWID_CMD_IDENT;             // RQ13 RQ20
                        else if (next_shift == `FWID_OP_STATUS)
                            cmd <= fwid_pkg::FWID_CMD_STATUS;            // RQ20
                        else
                            cmd <= fwid_pkg::FWID_CMD_IGNORE;
                    end
                end
            end
        end
    end

    // power state and self-timed program
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr         <= FWID_ST_AWAKE;
            timer       <= 32'd0;
            prog_run    <= 1'b0;
            page_stored <= `FWID_PAGE_RESET;                            // RQ6
            page_binary <= `FWID_PAGE_RESET;
            strap_sync  <= 2'h0;
            strap_age   <= 2'h0;
        end else begin
            // strap is a pin: two flops before it is taken
            strap_sync <= {strap_sync[0], page_strap};
            if (strap_age != 2'h3)
                strap_age <= strap_age + 2'h1;
            if (strap_age == 2'h2) begin
                page_stored <= strap_sync[1];
                page_binary <= strap_sync[1];                           // RQ9
            end
            if (timer != 32'd0)
                timer <= timer - 32'd1;
            unique case (pwr)
                FWID_ST_AWAKE: begin
                    if (frame_end && whole_byte && sleep_ok && byte_cnt == 3'd1 && !prog_run) begin
                        pwr   <= FWID_ST_ENTER;
                        timer <= `FWID_SLEEP_CYC;
                    end
                end
                FWID_ST_ENTER: if (timer == 32'd0) pwr <= FWID_ST_ASLEEP;
                FWID_ST_ASLEEP: begin
                    if (frame_end && whole_byte && wake_ok && byte_cnt == 3'd1) begin // RQ1 RQ4
                        pwr   <= FWID_ST_WAKE;
                        timer <= WAKE_CYC;                              // RQ2
                    end
                end
                FWID_ST_WAKE: if (timer == 32'd0) pwr <= FWID_ST_AWAKE; // RQ2 RQ3
            endcase
            if (awake && frame_end && whole_byte && cfg_ok && byte_cnt == 3'd4
                && !page_stored) begin
                prog_run <= 1'b1;                                       // RQ7 RQ8
                timer    <= PROG_CYC;
            end else if (prog_run && timer == 32'd0) begin
                prog_run    <= 1'b0;
                page_stored <= 1'b1;                                    // RQ5 RQ9
            end
        end
    end

    // serial output: shifted on falling clock edge, msb first
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            so_oe    <= 1'b0;
            so_out   <= 1'b0;
            out_byte <= 8'h00;
            out_bit  <= 3'd0;
            out_idx  <= 2'd0;
        end else if (!link.sel) begin
            so_oe   <= 1'b0;                                            // RQ15
            out_bit <= 3'd0;
            out_idx <= 2'd0;
        end else if (link.sck.fall) begin
            if (cmd == fwid_pkg::FWID_CMD_IDENT || cmd == fwid_pkg::FWID_CMD_STATUS) begin
                so_oe <= 1'b1;
                if (out_bit == 3'd0) begin
                    so_out   <= (cmd == fwid_pkg::FWID_CMD_IDENT) ?
                                id_now[7] : status_byte[7];              // RQ13 RQ14
                    out_byte <= (cmd == fwid_pkg::FWID_CMD_IDENT) ?
                                id_now : status_byte;
                    if (cmd == fwid_pkg::FWID_CMD_IDENT && out_idx != 2'd3)
                        out_idx <= out_idx + 2'd1;
                end else begin
                    so_out <= out_byte[3'd7 - out_bit];
                end
                out_bit <= out_bit + 3'd1;
            end
        end
    end
endmodule // fwid_core
`default_nettype wire

//--- hdl/fwid_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-stage synchronisers for the link pins, edge detect on the second stage
module fwid_sync (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         cs_n_pin,
    input  wire logic         sck_pin,
    input  wire logic         si_pin,
    output wire  fwid_pkg::fwid_link_t link
);
    logic [2:0] meta;
    logic [2:0] stable;
    logic       sck_last;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta     <= 3'h7;
            stable   <= 3'h7;
            sck_last <= 1'b1;
        end else begin
            meta     <= {cs_n_pin, sck_pin, si_pin};
            stable   <= meta;
            sck_last <= stable[1];
        end
    end

    assign link.sel       = ~stable[2];
    assign link.sck.level = stable[1];
    assign link.sck.rise  = stable[1] & ~sck_last;
    assign link.sck.fall  = ~stable[1] & sck_last;
    assign link.si        = stable[0];
endmodule // fwid_sync
`default_nettype wire

//--- inc/fwid_map.svh
`ifndef FWID_MAP_SVH
`define FWID_MAP_SVH
// opcodes
`define FWID_OP_WAKE        8'hab
`define FWID_OP_SLEEP       8'hb9
`define FWID_OP_IDENT       8'h9f
`define FWID_OP_STATUS      8'hd7
`define FWID_OP_CFG0        8'h3d
`define FWID_OP_CFG1        8'h2a
`define FWID_OP_CFG2        8'h80
`define FWID_OP_CFG3        8'ha6
// identification bytes (values arbitrary)
`define FWID_MAKER_CODE     8'h5a
`define FWID_FAMILY         3'h2
`define FWID_DENSITY        5'h0b
`define FWID_CELL_LEVEL     3'h1
`define FWID_VERSION        5'h03
`define FWID_EXTRA_COUNT    8'h00
// status register layout
`define FWID_ST_READY_BIT   7
`define FWID_ST_PAGE_BIT    0
`define FWID_ST_DENSITY     4'h7
// page size reset value: 0 selects 264-byte pages
`define FWID_PAGE_RESET     1'b0
// timing
`define FWID_CLK_NS         40
`define FWID_WAKE_US        35
`define FWID_WAKE_CYC       ((`FWID_WAKE_US * 1000) / `FWID_CLK_NS)
`define FWID_SLEEP_US       3
`define FWID_SLEEP_CYC      ((`FWID_SLEEP_US * 1000) / `FWID_CLK_NS)
`define FWID_PROG_MS        4
`define FWID_PROG_CYC       ((`FWID_PROG_MS * 1000000) / `FWID_CLK_NS)
`endif

//--- inc/fwid_pkg.sv
package fwid_pkg;
    typedef enum logic [1:0] {
        FWID_CMD_NONE,
        FWID_CMD_IDENT,
        FWID_CMD_STATUS,
        FWID_CMD_IGNORE
    } fwid_cmd_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic level;
    } fwid_edge_t;

    typedef struct packed {
        logic       sel;
        fwid_edge_t sck;
        logic       si;
    } fwid_link_t;
endpackage

//--- testbench/fwid_core_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module fwid_core_asserts #(
    parameter int unsigned WAKE_CYC = 20,
    parameter int unsigned PROG_CYC = 50
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic page_strap,
    input wire logic so_oe,
    input wire logic busy,
    input wire logic deep_sleep,
    input wire logic page_binary,
    input wire logic page_stored
);
    localparam int unsigned BUSY_MAX = (WAKE_CYC > PROG_CYC ? WAKE_CYC : PROG_CYC) + 80;
    logic [2:0]  since_rst;
    logic [31:0] busy_run;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            since_rst <= 3'h0;
            busy_run  <= 32'h0;
        end else begin
            since_rst <= since_rst + {2'h0, since_rst != 3'h7};
            busy_run  <= busy ? busy_run + 32'h1 : 32'h0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    property p_oe_off; cs_n [*6] |-> !so_oe; endproperty
    a_oe_off: assert property (p_oe_off) else $error("so still driven");
    property p_oe_sel; $rose(so_oe) |-> !cs_n; endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("so driven unselected");
    property p_sleep_quiet; deep_sleep |-> !so_oe; endproperty
    a_sleep_quiet: assert property (p_sleep_quiet) else $error("answer in sleep");
    property p_page_active; since_rst > 3'h3 |-> $stable(page_binary); endproperty
    a_page_active: assert property (p_page_active) else $error("page size moved");
    property p_stored_keep; page_stored && since_rst > 3'h3 |=> page_stored; endproperty
    a_stored_keep: assert property (p_stored_keep) else $error("setting reverted");
    property p_strap; since_rst == 3'h4 |-> page_binary == page_strap; endproperty
    a_strap: assert property (p_strap) else $error("start page size wrong");
    property p_busy_len; busy |-> busy_run < BUSY_MAX; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy too long");
    property p_wake_cs; $fell(deep_sleep) |-> cs_n; endproperty
    a_wake_cs: assert property (p_wake_cs) else $error("woke while selected");
endmodule // fwid_core_asserts
bind fwid_core fwid_core_asserts #(.WAKE_CYC(WAKE_CYC), .PROG_CYC(PROG_CYC)) fwid_core_asserts_inst (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .page_strap(page_strap), .so_oe(so_oe),
    .busy(busy), .deep_sleep(deep_sleep), .page_binary(page_binary), .page_stored(page_stored)
);
`default_nettype wire

//--- testbench/fwid_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "fwid_map.svh"
module fwid_core_tb_top;
    localparam int unsigned WAKE = 200;
    localparam int unsigned PROG = 400;
    localparam logic [31:0] CFG = {`FWID_OP_CFG0, `FWID_OP_CFG1, `FWID_OP_CFG2, `FWID_OP_CFG3};
    localparam logic [31:0] IDS = {`FWID_MAKER_CODE, `FWID_FAMILY, `FWID_DENSITY,
        `FWID_CELL_LEVEL, `FWID_VERSION, `FWID_EXTRA_COUNT};
    logic       clk, reset_n, page_strap, cs_n, sck, si, so_out, so_oe, got_stb, strap;
    logic       busy, deep_sleep, page_binary, page_stored;
    logic [7:0] got;
    logic [7:0] expq[$];
    int         miscompares, samples_checked, cycles, seed;
    fwid_core #(.WAKE_CYC(WAKE), .PROG_CYC(PROG)) fwid_core_inst (
        .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si), .page_strap(page_strap),
        .so_out(so_out), .so_oe(so_oe), .busy(busy), .deep_sleep(deep_sleep),
        .page_binary(page_binary), .page_stored(page_stored));
    fwid_host_model fwid_host_model_inst (.clk(clk), .so_out(so_out), .so_oe(so_oe),
        .cs_n(cs_n), .sck(sck), .si(si), .got(got), .got_stb(got_stb));
    always #20 clk = ~clk;
    function automatic logic [7:0] st(input logic bsy, input logic pg);
        return {~bsy, 1'b0, `FWID_ST_DENSITY, 1'b0, pg};
    endfunction
    task automatic check(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic send(input logic [47:0] tx, input int n);
        fwid_host_model_inst.frame(tx, n, 1'b0);
    endtask
    task automatic read_cmd(input logic [7:0] op, input logic [31:0] e, input int n);
        for (int i = 0; i < n; i++) expq.push_back(e[31-8*i -: 8]);
        fwid_host_model_inst.frame({op, 40'h0}, 8 + 8 * n, 1'b1);
    endtask
    task automatic wait_idle(input int lim);
        for (int k = 0; k < lim && busy !== 1'b0; k++) @(posedge clk);
    endtask
    task automatic power_cycle(input logic s);
        reset_n <= 1'b0;
        page_strap <= s;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
    task automatic give_verdict;
        $display("checked %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (got_stb === 1'b1) check(got, expq.pop_front());
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        page_strap = 1'b0;
        seed = 33705;
        power_cycle(1'b0);
        read_cmd(`FWID_OP_STATUS, {st(1'b0, 1'b0), st(1'b0, 1'b0), 16'h0}, 2);
        read_cmd(`FWID_OP_IDENT, IDS, 4);
        send({`FWID_OP_IDENT, 40'h0}, 20);
        check({7'h00, so_oe}, 8'h00);
        send({CFG, 16'h0}, 28);
        send({CFG ^ 32'h1, 16'h0}, 32);
        check({6'h00, busy, page_stored}, 8'h00);
        send({CFG, 16'h0}, 32);
        check({7'h00, busy}, 8'h01);
        read_cmd(`FWID_OP_STATUS, {st(1'b1, 1'b0), st(1'b1, 1'b0), 16'h0}, 2);
        wait_idle(PROG);
        check({5'h00, busy, page_binary, page_stored}, 8'h01);
        send({CFG, 16'h0}, 32);
        check({7'h00, busy}, 8'h00);
        send({`FWID_OP_SLEEP, 40'h0}, 8);
        wait_idle(200);
        send({`FWID_OP_IDENT, 40'h0}, 40);
        send({`FWID_OP_WAKE, 40'h0}, 4);
        check({6'h00, busy, deep_sleep}, 8'h01);
        send({`FWID_OP_WAKE, 40'h0}, 8);
        check({7'h00, busy}, 8'h01);
        wait_idle(WAKE + 8);
        check({6'h00, busy, deep_sleep}, 8'h00);
        for (int n = 0; n < 2; n++) begin
            strap = 1'($random(seed));
            power_cycle(strap);
            read_cmd(`FWID_OP_STATUS, {st(1'b0, strap), st(1'b0, strap), 16'h0}, 2);
            check({6'h00, page_binary, page_stored}, {6'h00, strap, strap});
        end
        give_verdict();
    end
endmodule // fwid_core_tb_top
`default_nettype wire

//--- testbench/fwid_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// host side of the link, sck idles high between frames
module fwid_host_model (
    input  wire logic       clk,
    input  wire logic       so_out,
    input  wire logic       so_oe,
    output var  logic       cs_n,
    output var  logic       sck,
    output var  logic       si,
    output var  logic [7:0] got,
    output var  logic       got_stb
);
    logic [7:0] sh;
    initial begin
        cs_n = 1'b1;
        sck = 1'b1;
        si = 1'b0;
        got = 8'h00;
        got_stb = 1'b0;
    end
    // one frame at a time; busy is not checked, so a frame can start during a command in progress
    task automatic frame(input logic [47:0] tx, input int nbits, input logic rd);
        @(posedge clk) cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        // sck period of eight clocks, strobe high for one clock
        for (int i = 0; i < nbits; i++) begin
            sck <= 1'b0;
            si <= tx[47-i];
            @(posedge clk) got_stb <= 1'b0;
            repeat (3) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            sh = {sh[6:0], so_oe ? so_out : 1'bx};
            got <= sh;
            got_stb <= rd && i >= 15 && i % 8 == 7;
        end
        @(posedge clk) got_stb <= 1'b0;
        repeat (3) @(posedge clk);
        cs_n <= 1'b1;
        si <= ~si;
        repeat (8) @(posedge clk);
    endtask
endmodule // fwid_host_model
`default_nettype wire
